// ### logic/pix_lut.sv
// 256 x 16 colour lookup table, one write/read port for software, one read port for pixels
`timescale 1ns/1ns
`default_nettype none
module pix_lut
    import pix_pkg::*;
(
    input  wire logic        clk,        // core clock
    input  wire logic        sw_we,      // software write
    input  wire logic [7:0]  sw_index,   // software index
    input  wire logic [15:0] sw_wdata,   // software write data
    output logic      [15:0] sw_rdata,   // software read data, next cycle
    input  wire logic [7:0]  pix_index,  // pixel index
    output logic      [15:0] pix_entry   // looked-up entry, next cycle
);
    logic [15:0] color_lookup_table [LUT_DEPTH];

    // contents undefined until software loads them
    always_ff @(posedge clk)
    begin
        if (sw_we)
            color_lookup_table[sw_index] <= sw_wdata;
    end

    always_ff @(posedge clk)
    begin
        sw_rdata  <= color_lookup_table[sw_index];
        pix_entry <= color_lookup_table[pix_index];
    end
endmodule
`default_nettype wire

// ### logic/pix_pkg.sv
// shared constants for the pixel serializer and palette
package pix_pkg;
    // pixel depth codes
    localparam logic [2:0] DEPTH_1  = 3'h0;
    localparam logic [2:0] DEPTH_2  = 3'h1;
    localparam logic [2:0] DEPTH_4  = 3'h2;
    localparam logic [2:0] DEPTH_8  = 3'h3;
    localparam logic [2:0] DEPTH_16 = 3'h4;
    localparam logic [2:0] DEPTH_24 = 3'h5;
    // memory order codes
    localparam logic [1:0] ORDER_LE   = 2'h0;
    localparam logic [1:0] ORDER_BE   = 2'h1;
    localparam logic [1:0] ORDER_BYTE = 2'h2;
    // display type codes
    localparam logic [1:0] DISP_STN_MONO  = 2'h0;
    localparam logic [1:0] DISP_STN_COLOR = 2'h1;
    localparam logic [1:0] DISP_TFT       = 2'h2;
    // register map, byte addresses
    localparam logic [11:0] ADDR_FORMAT = 12'h0000;
    localparam logic [11:0] ADDR_STATUS = 12'h0004;
    localparam logic [11:0] ADDR_LUT    = 12'h0400;
    localparam logic [11:0] ADDR_LUT_END = 12'h07FC;
    // format register fields
    localparam int DEPTH_LSB = 0;
    localparam int ORDER_LSB = 4;
    localparam int DISP_LSB  = 8;
    localparam int PACK_BIT  = 12;
    localparam logic [12:0] FORMAT_RESET = 13'h0000;
    localparam int LUT_DEPTH = 256;
    localparam int WORD_BITS = 32;
endpackage

// ### logic/pix_word_slicer.sv
// extracts one pixel from a word, or in little endian order a packed 24-bit pixel from two words
`timescale 1ns/1ns
`default_nettype none
module pix_word_slicer
    import pix_pkg::*;
(
    input  wire logic [31:0] cur_word,   // current word
    input  wire logic [31:0] prev_word,  // previous word, for straddles
    input  wire logic [5:0]  bit_pos,    // pixel offset in word, from first bit
    input  wire logic [2:0]  depth,      // pixel depth code
    input  wire logic [1:0]  order,      // memory order code
    output logic      [23:0] pixel       // pixel value, low aligned
);
    function automatic logic [5:0] width_of(input logic [2:0] d);
        unique case (d)
            DEPTH_1:  width_of = 6'h01;
            DEPTH_2:  width_of = 6'h02;
            DEPTH_4:  width_of = 6'h04;
            DEPTH_8:  width_of = 6'h08;
            DEPTH_16: width_of = 6'h10;
            default:  width_of = 6'h18;
        endcase
    endfunction

    logic [5:0]  w;
    logic [63:0] pair;
    logic [31:0] shifted;
    logic [31:0] mask;
    logic [4:0]  lsb;

    always_comb
    begin
        w    = width_of(depth);
        mask = (32'h0000_0001 << w) - 32'h0000_0001;
        lsb  = 5'h00;
        pair = {cur_word, prev_word};
        shifted = 32'h0000_0000;
        unique case (order)
            ORDER_BE:
            begin
                // first pixel at bit 31
                lsb     = 5'(6'h20 - bit_pos - w);
                shifted = cur_word >> lsb;
            end
            ORDER_BYTE:
            begin
                if (w >= 6'h08)
                    lsb = bit_pos[4:0];
                else
                    lsb = {bit_pos[4:3], 3'(4'h8 - {1'b0, bit_pos[2:0]} - w[3:0])};
                shifted = cur_word >> lsb;
            end
            default:
            begin
                // packed 24 straddle reads across the older and newer word
                if (bit_pos > 6'h08 && w == 6'h18)
                    shifted = 32'(pair >> bit_pos);
                else
                    shifted = cur_word >> bit_pos[4:0];
            end
        endcase
        pixel = 24'(shifted & mask);
    end
endmodule
`default_nettype wire

// ### logic/pixel_serializer_palette.sv
// pixel serializer with palette lookup and software register port
// How it works
// - words split into 1..24-bit pixels by depth
// - big or little endian per order field
// - little starts at bit 0, big at 31
// - byte order with msb-first pixels inside bytes
// - 24-bit packed straddles words in little endian order, unpacked uses low 24
// - small pixels index the lookup table
// - palette use by display type and depth
// - table readable and writable by software
// - entries in low 16 bits of words
// - 256 entries of 16 bits
// - entry is red5, green6, blue5
// - mono uses red upper four bits
// - colour stn uses upper four bits each
// - tft palettized zeroes unused data lines
// - new pixel only on data request
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module pixel_serializer_palette
    import pix_pkg::*;
(
    input  wire logic        clk,            // core clock, 50 MHz
    input  wire logic        reset_n,        // synchronous reset, active low
    input  wire logic [11:0] reg_addr,       // register byte address
    input  wire logic [31:0] reg_wdata,      // register write data
    input  wire logic        reg_wr,         // write strobe
    input  wire logic        reg_rd,         // read strobe
    output logic      [31:0] reg_rdata,      // read data, cycle after strobe
    input  wire logic [31:0] fifo_data,      // fifo head word
    input  wire logic        fifo_empty,     // fifo has no word
    output logic             fifo_pop,       // take head word
    input  wire logic        data_request,   // downstream wants a pixel
    output logic      [23:0] panel_data_bus, // pixel out
    output logic             pixel_valid,    // panel_data_bus holds a new pixel, one cycle
    output logic             underrun        // request met an empty stream, sticky
);
    logic [12:0] display_format_ctrl;
    logic [2:0]  pixel_depth_sel;
    logic [1:0]  memory_order_sel;
    logic [1:0]  display_type_sel;
    logic        packed_24;

    assign pixel_depth_sel  = display_format_ctrl[DEPTH_LSB +: 3];
    assign memory_order_sel = display_format_ctrl[ORDER_LSB +: 2];
    assign display_type_sel = display_format_ctrl[DISP_LSB +: 2];
    assign packed_24        = display_format_ctrl[PACK_BIT];

    function automatic logic [5:0] depth_bits(input logic [2:0] d);
        unique case (d)
            DEPTH_1:  depth_bits = 6'h01;
            DEPTH_2:  depth_bits = 6'h02;
            DEPTH_4:  depth_bits = 6'h04;
            DEPTH_8:  depth_bits = 6'h08;
            DEPTH_16: depth_bits = 6'h10;
            default:  depth_bits = 6'h18;
        endcase
    endfunction

    function automatic logic uses_palette(input logic [1:0] t, input logic [2:0] d);
        unique case (t)
            DISP_TFT:       uses_palette = (d <= DEPTH_8);
            DISP_STN_MONO:  uses_palette = (d <= DEPTH_2);
            default:        uses_palette = (d <= DEPTH_8);
        endcase
    endfunction

    // register port
    logic lut_hit;
    logic lut_hit_q;
    logic [31:0] plain_rdata;
    logic [15:0] lut_rdata;
    logic [1:0]  status_bits;

    assign lut_hit = reg_addr >= ADDR_LUT && reg_addr <= ADDR_LUT_END;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            display_format_ctrl <= FORMAT_RESET;
        else if (reg_wr && reg_addr == ADDR_FORMAT)
            display_format_ctrl <= reg_wdata[12:0];
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            lut_hit_q   <= 1'b0;
            plain_rdata <= 32'h0000_0000;
        end
        else
        begin
            lut_hit_q <= reg_rd && lut_hit;
            if (reg_rd && reg_addr == ADDR_FORMAT)
                plain_rdata <= {19'h0_0000, display_format_ctrl};
            else if (reg_rd && reg_addr == ADDR_STATUS)
                plain_rdata <= {30'h0000_0000, status_bits};
            else
                plain_rdata <= 32'h0000_0000;
        end
    end

    // lookup entry reads back zero-extended from low half
    assign reg_rdata = lut_hit_q ? {16'h0000, lut_rdata} : plain_rdata;

    // serializer state
    typedef enum logic [2:0] {
        S_LOAD  = 3'b001,
        S_SLICE = 3'b010,
        S_LOOK  = 3'b100
    } ser_state_e;
    ser_state_e state;

    logic [31:0] cur_word;
    logic [31:0] prev_word;
    logic [5:0]  bit_pos;
    logic [23:0] sliced;
    logic [5:0]  width;
    logic [5:0]  next_pos;
    logic        need_word;
    logic        straddle;
    logic        pal_q;
    logic [23:0] raw_q;
    logic [15:0] pix_entry;
    logic        tail_loaded;

    assign width    = depth_bits(pixel_depth_sel);
    assign next_pos = bit_pos + width;
    // packed 24-bit: slot positions 0,24,16,8 through three words
    assign straddle = pixel_depth_sel == DEPTH_24 && packed_24 && bit_pos > 6'h08 && bit_pos < 6'h20;
    // a straddle needs one extra load, then little endian order slices from the word pair
    assign need_word = (straddle && !tail_loaded) || bit_pos >= 6'h20;

    pix_word_slicer u_slicer (
        .cur_word  (cur_word),
        .prev_word (prev_word),
        .bit_pos   (bit_pos),
        .depth     (pixel_depth_sel),
        .order     (memory_order_sel),
        .pixel     (sliced)
    );

    pix_lut u_lut (
        .clk       (clk),
        .sw_we     (reg_wr && lut_hit),
        .sw_index  (reg_addr[9:2]),
        .sw_wdata  (reg_wdata[15:0]),
        .sw_rdata  (lut_rdata),
        .pix_index (sliced[7:0]),
        .pix_entry (pix_entry)
    );

    // bit 0 shows the serializer waiting on the fifo
    assign status_bits = {underrun, state == S_LOAD};

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state     <= S_LOAD;
            cur_word  <= 32'h0000_0000;
            prev_word <= 32'h0000_0000;
            bit_pos   <= 6'h00;
            fifo_pop  <= 1'b0;
            tail_loaded <= 1'b0;
        end
        else
        begin
            fifo_pop <= 1'b0;
            unique case (state)
                S_LOAD:
                begin
                    // pop is registered, so word is taken directly and fifo head advances next cycle
                    if (!fifo_empty && !fifo_pop)
                    begin
                        prev_word <= cur_word;
                        cur_word  <= fifo_data;
                        fifo_pop  <= 1'b1;
                        bit_pos   <= (bit_pos >= 6'h20) ? bit_pos - 6'h20 : bit_pos;
                        // straddle load keeps bit_pos on the older word
                        tail_loaded <= straddle;
                        state     <= S_SLICE;
                    end
                end
                S_SLICE:
                begin
                    if (need_word)
                        state <= S_LOAD;
                    else if (data_request)
                    begin
                        // unpacked 24 consumes whole word, ignoring top byte
                        if (pixel_depth_sel == DEPTH_24 && !packed_24)
                            bit_pos <= 6'h20;
                        else if (tail_loaded)
                            // straddle done, position now counts from the newer word
                            bit_pos <= next_pos - 6'h20;
                        else
                            bit_pos <= next_pos;
                        tail_loaded <= 1'b0;
                        state <= S_LOOK;
                    end
                end
                default:
                    state <= S_SLICE;
            endcase
        end
    end

    // straddling pixel resolves after the next word arrives
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pal_q <= 1'b0;
            raw_q <= 24'h00_0000;
        end
        else if (state == S_SLICE && data_request && !need_word)
        begin
            pal_q <= uses_palette(display_type_sel, pixel_depth_sel);
            // unpacked 24 sits in the low bits in every memory order
            if (pixel_depth_sel == DEPTH_24 && !packed_24)
                raw_q <= cur_word[23:0];
            else
                raw_q <= sliced;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            panel_data_bus <= 24'h00_0000;
            pixel_valid    <= 1'b0;
        end
        else
        begin
            pixel_valid <= state == S_LOOK;
            if (state == S_LOOK)
            begin
                if (!pal_q)
                    panel_data_bus <= raw_q;
                else unique case (display_type_sel)
                    DISP_TFT:
                        // red 23:19, green 15:10, blue 7:3, other lines zero
                        panel_data_bus <= {pix_entry[15:11], 3'h0, pix_entry[10:5], 2'h0, pix_entry[4:0], 3'h0};
                    DISP_STN_MONO:
                        panel_data_bus <= {20'h0_0000, pix_entry[15:12]};
                    default:
                        panel_data_bus <= {12'h000, pix_entry[15:12], pix_entry[10:7], pix_entry[4:1]};
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            underrun <= 1'b0;
        // set is tested first, so an underrun in the clearing cycle is kept
        else if (data_request && state == S_LOAD && fifo_empty)
            underrun <= 1'b1;
        else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[1])
            underrun <= 1'b0;
    end

    chk_valid_needs_request: assert property (@(posedge clk) disable iff (!reset_n)
        pixel_valid |-> $past(data_request, 2))
        else $error("pixel without request");
    chk_pop_single: assert property (@(posedge clk) disable iff (!reset_n)
        fifo_pop |=> !fifo_pop)
        else $error("double pop");
    chk_pop_not_empty: assert property (@(posedge clk) disable iff (!reset_n)
        fifo_pop |-> $past(!fifo_empty))
        else $error("pop from empty fifo");
    chk_tft_zero_lines: assert property (@(posedge clk) disable iff (!reset_n)
        pixel_valid && display_type_sel == DISP_TFT && pal_q
        |-> panel_data_bus[18:16] == 3'h0 && panel_data_bus[9:8] == 2'h0 && panel_data_bus[2:0] == 3'h0)
        else $error("tft unused lines not zero");
    chk_mono_gray: assert property (@(posedge clk) disable iff (!reset_n)
        pixel_valid && display_type_sel == DISP_STN_MONO && pal_q |-> panel_data_bus[23:4] == 20'h0_0000)
        else $error("mono gray wider than four bits");
    chk_bypass_pass: assert property (@(posedge clk) disable iff (!reset_n)
        pixel_valid && !pal_q |-> panel_data_bus == raw_q)
        else $error("bypass pixel changed");
    chk_lut_readback: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && lut_hit |=> reg_rdata[31:16] == 16'h0000)
        else $error("lut upper half not zero");
    chk_mono_palette: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_SLICE && data_request && !need_word && display_type_sel == DISP_STN_MONO
        && pixel_depth_sel == DEPTH_4 |=> !pal_q)
        else $error("mono 4-bit used palette");
    chk_pos_in_word: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_LOOK |-> bit_pos <= 6'h20)
        else $error("pixel position beyond word");
    chk_unpacked_low: assert property (@(posedge clk) disable iff (!reset_n)
        state == S_LOOK && pixel_depth_sel == DEPTH_24 && !packed_24 |-> raw_q == cur_word[23:0])
        else $error("unpacked 24-bit pixel not from low bits");
endmodule
`default_nettype wire

// ### tb/pixel_serializer_palette_tb_top.sv
// self-checking bench for the pixel serializer and palette
`timescale 1ns/1ns
`default_nettype none
module pixel_serializer_palette_tb_top
    import pix_pkg::*;
;
    logic        clk, reset_n, reg_wr, reg_rd, fifo_empty, fifo_pop;
    logic        data_request, pixel_valid, underrun, active, slow;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fifo_data, rd;
    logic [23:0] panel_data_bus;
    logic [15:0] lut[256];
    logic [31:0] fq[$], words[$];
    int          n_mismatch, checks;

    pixel_serializer_palette pixel_serializer_palette_i (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fifo_data(fifo_data), .fifo_empty(fifo_empty),
        .fifo_pop(fifo_pop), .data_request(data_request), .panel_data_bus(panel_data_bus),
        .pixel_valid(pixel_valid), .underrun(underrun));
    pixel_sink pixel_sink_i (.clk(clk), .reset_n(reset_n), .active(active), .slow(slow),
        .pixel_valid(pixel_valid), .panel_data_bus(panel_data_bus), .data_request(data_request));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // head toggles between the last word and its inverse once empty, so stale reads show up
    always @(posedge clk)
    begin
        if (fifo_pop && fq.size() != 0)
            void'(fq.pop_front());
        fifo_empty <= (fq.size() == 0);
        fifo_data  <= (fq.size() != 0) ? fq[0] : ~fifo_data;
    end

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pix(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t pixel got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [11:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [23:0] slice(input int k, input int d, input logic [1:0] o, input bit pk);
        logic [31:0] w, m;
        logic [63:0] w2;
        int          p;
        p = (k * d) % 32;
        m = (32'h0000_0001 << d) - 1;
        if (d == 24 && !pk)
            return words[k][23:0];
        if (d == 24)
        begin
            w2 = {words[k * 24 / 32 + 1], words[k * 24 / 32]};
            return 24'(w2 >> p);
        end
        w = words[k * d / 32];
        if (o == ORDER_BE)
            return 24'((w >> (32 - p - d)) & m);
        if (o == ORDER_BYTE && d < 8)
            return 24'((w >> (p / 8 * 8 + 8 - p % 8 - d)) & m);
        return 24'((w >> p) & m);
    endfunction

    function automatic logic [23:0] expect_out(input logic [23:0] pix, input logic [1:0] typ, input logic [2:0] dep);
        logic [15:0] e;
        e = lut[pix[7:0]];
        if (dep > DEPTH_8 || (typ == DISP_STN_MONO && dep == DEPTH_4))
            return pix;
        if (typ == DISP_TFT)
            return {e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0};
        if (typ == DISP_STN_COLOR)
            return {12'h000, e[15:12], e[10:7], e[4:1]};
        return {20'h0_0000, e[15:12]};
    endfunction

    task automatic run_stream(input logic [1:0] typ, input logic [2:0] dep, input logic [1:0] o, input bit pk);
        int n, t, d;
        d = (dep == DEPTH_24) ? 24 : (1 << dep);
        n = (d == 24) ? (pk ? 4 : 3) : 96 / d;
        @(posedge clk);
        reset_n <= 1'b0;
        active  <= 1'b0;
        slow    <= (o == ORDER_BE);
        @(posedge clk);
        reset_n <= 1'b1;
        pixel_pkg_clear();
        reg_write(ADDR_FORMAT, 32'(dep) | (32'(o) << ORDER_LSB) | (32'(typ) << DISP_LSB) | (32'(pk) << PACK_BIT));
        words = '{32'h8000_0001, $urandom, $urandom};
        #1 foreach (words[i]) fq.push_back(words[i]);
        repeat (8) @(posedge clk);
        cmp_reg(32'(pixel_sink_i.got.size()), 32'h0000_0000);
        active <= 1'b1;
        for (t = 0; t < 3000 && pixel_sink_i.got.size() < n; t++)
            @(posedge clk);
        if (t == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
        repeat (12) @(posedge clk);
        cmp_reg(32'(pixel_sink_i.got.size()), 32'(n));
        for (int k = 0; k < n; k++)
            cmp_pix(pixel_sink_i.got[k], expect_out(slice(k, d, o, pk), typ, dep));
        cmp_reg({31'h0000_0000, underrun}, 32'h0000_0001);
        active <= 1'b0;
        repeat (4) @(posedge clk);
        reg_read(ADDR_STATUS);
        cmp_reg(rd & 32'h0000_0003, 32'h0000_0003);
        reg_write(ADDR_STATUS, 32'h0000_0002);
        reg_read(ADDR_STATUS);
        cmp_reg(rd & 32'h0000_0003, 32'h0000_0001);
        $display("test stream type %0d depth %0d order %0d packed %0d done", typ, dep, o, pk);
    endtask

    task automatic pixel_pkg_clear;
        pixel_sink_i.got.delete();
    endtask

    logic [1:0] ct[14] = '{0, 0, 0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
    logic [2:0] cd[14] = '{0, 1, 2, 0, 1, 2, 3, 4, 0, 1, 2, 3, 4, 5};

    initial
    begin
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 12'h000;
        reg_wdata  = 32'h0000_0000;
        fifo_empty = 1'b1;
        fifo_data  = 32'h0000_0000;
        active     = 1'b0;
        slow       = 1'b0;
        reset_n    = 1'b0;
        n_mismatch = 0;
        checks     = 0;
        rd = $urandom(32'h4d42_7474);
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        reg_read(ADDR_FORMAT);
        cmp_reg(rd, 32'(FORMAT_RESET));
        for (int i = 0; i < LUT_DEPTH; i++)
        begin
            rd = (i == 255) ? 32'hffff_ffff : $urandom;
            lut[i] = rd[15:0];
            reg_write(ADDR_LUT + 12'(i * 4), rd);
        end
        for (int i = 0; i < LUT_DEPTH; i++)
        begin
            reg_read(ADDR_LUT + 12'(i * 4));
            cmp_reg(rd, {16'h0000, lut[i]});
        end
        reg_write(12'h100, 32'hffff_ffff);
        reg_read(12'h100);
        cmp_reg(rd, 32'h0000_0000);
        $display("test registers done");
        for (int c = 0; c < 14; c++)
            for (int o = 0; o < 3; o++)
                for (int pk = 0; pk < 2; pk++)
                    if (pk == 0 || (cd[c] == DEPTH_24 && o == 0))
                        run_stream(ct[c], cd[c], 2'(o), pk[0]);
        stop_test();
    end
endmodule
`default_nettype wire

// ### tb/pixel_sink.sv
// downstream pixel consumer model: requests pixels and records them
`timescale 1ns/1ns
`default_nettype none
module pixel_sink
(
    input  wire logic        clk,            // core clock
    input  wire logic        reset_n,        // sync reset, active low
    input  wire logic        active,         // keep requesting
    input  wire logic        slow,           // drop requests at random
    input  wire logic        pixel_valid,    // new pixel strobe
    input  wire logic [23:0] panel_data_bus, // pixel in
    output logic             data_request    // pixel wanted
);
    logic [23:0] got[$];

    always @(posedge clk)
    begin
        if (!reset_n)
            data_request <= 1'b0;
        else
            data_request <= active && (!slow || $urandom_range(3) != 0);
        if (reset_n && pixel_valid)
            got.push_back(panel_data_bus);
    end
endmodule
`default_nettype wire
